// ---- hw/line_draw_host.sv ----
/*
 * Host controller for the line-draw mode of a bit-block engine. Software
 * gives endpoints, texture and plane geometry over Avalon-MM; the block
 * computes every line-mode register and writes them to the engine, the
 * size word last, then waits for the engine to finish.
 * Assumes the engine port raises busy within a few cycles of the size
 * write and holds it until the line is drawn; one 200 MHz clock.
 */
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - bits 4..2 of the second control word carry the octant code
// - parameters come from major delta dx and minor delta dy
// - first pointer holds 4dy-2dx; sign flag set when it is negative
// - first modulo is 4(dy-dx), second modulo is 4dy
// - line bit data is 8000, both word masks are ffff
// - first source shift, bits 15..12, gets x1 modulo 15
// - texture data holds the pattern; its start bit goes in bits 15..12
// - original and destination pointers at first pixel word, modulos plane width
// - first, original and destination channels on, second off, overflow clear
// - logic byte is the plain line function, or the xor variant
// - size height is dx+1 in bits 15..6, width two in bits 5..0
// - the size word is written only after all other registers
module line_draw_host (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// avalon-mm slave
	input wire logic [4:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [3:0] i_byteenable,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// engine register port
	output logic o_dev_write,
	output line_pkg::dev_write_t o_dev_entry,
	input wire logic i_dev_ready,
	input wire logic i_dev_busy
);
	import line_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_WAIT_ACK = 3'b011,
		ST_WAIT_RISE = 3'b100,
		ST_WAIT_FALL = 3'b101
	} state_t;

	state_t state, next_state;
	logic [2:0] mode;
	line_points_t points;
	logic [19:0] texture;
	logic [15:0] plane_width;
	logic [31:0] plane_base;
	logic done, too_long_err;
	logic [3:0] step, next_step;
	line_regs_t calc_regs, regs;
	logic calc_too_long;
	logic bus_ack, wr_ack, start_req, abort_req;
	logic [31:0] read_mux;
	dev_write_t entry;
	logic send, accepted;

	// byte-lane merge for a register write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] be);
		merge = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				merge[8 * i +: 8] = data[8 * i +: 8];
	endfunction : merge

	////////////////////////////////////////////////////////////////////////
	// avalon slave handshake: one wait cycle, answer on the second edge

	assign bus_ack = (i_read || i_write) && !o_waitrequest;
	assign wr_ack = i_write && !o_waitrequest;
	assign start_req = wr_ack && i_address == CSR_CONTROL && i_byteenable[0]
		&& i_writedata[CTL_START];
	assign abort_req = wr_ack && i_address == CSR_CONTROL && i_byteenable[0]
		&& i_writedata[CTL_ABORT];

	// waitrequest drops for exactly one cycle per request
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
			o_waitrequest <= 1'b1;
		else if (bus_ack)
			o_waitrequest <= 1'b1;
		else if (i_read || i_write)
			o_waitrequest <= 1'b0;
	end

	// read mux; unmapped offsets read zero
	always_comb
	begin
		read_mux = 32'h00000000;
		case (i_address)
			CSR_CONTROL: read_mux = {29'h00000000, mode};
			CSR_START_POINT: read_mux = {points.y1, points.x1};
			CSR_END_POINT: read_mux = {points.y2, points.x2};
			CSR_TEXTURE: read_mux = {12'h000, texture};
			CSR_PLANE_WIDTH: read_mux = {16'h0000, plane_width};
			CSR_PLANE_BASE: read_mux = plane_base;
			CSR_STATUS:
			begin
				read_mux[STA_BUSY] = state != ST_IDLE;
				read_mux[STA_DONE] = done;
				read_mux[STA_TOO_LONG] = too_long_err;
			end
			default: read_mux = 32'h00000000;
		endcase
	end

	// read data loaded when the request is taken, so it stands at the answering edge
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
			o_readdata <= 32'h00000000;
		else if (i_read && o_waitrequest)
			o_readdata <= read_mux;
	end

	////////////////////////////////////////////////////////////////////////
	// software-written line description

	// mode bits: single dot and xor drawing; start and abort are pulses only
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
			mode <= 3'h0;
		else if (wr_ack && i_address == CSR_CONTROL && i_byteenable[0])
			mode <= {i_writedata[CTL_XOR_MODE], i_writedata[CTL_SINGLE_DOT], 1'b0};
	end

	// geometry registers with byte enables
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			points <= '0;
			texture <= 20'h0ffff;
			plane_width <= 16'h0000;
			plane_base <= 32'h00000000;
		end
		else if (wr_ack)
		begin
			case (i_address)
				CSR_START_POINT:
					{points.y1, points.x1} <= merge({points.y1, points.x1}, i_writedata,
						i_byteenable);
				CSR_END_POINT:
					{points.y2, points.x2} <= merge({points.y2, points.x2}, i_writedata,
						i_byteenable);
				CSR_TEXTURE:
					texture <= 20'(merge({12'h000, texture}, i_writedata, i_byteenable));
				CSR_PLANE_WIDTH:
					plane_width <= 16'(merge({16'h0000, plane_width}, i_writedata,
						i_byteenable));
				CSR_PLANE_BASE:
					plane_base <= merge(plane_base, i_writedata, i_byteenable);
				default:
					plane_base <= plane_base;
			endcase
		end
	end

	// sticky status flags: a hardware set wins over a software clear
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			done <= 1'b0;
			too_long_err <= 1'b0;
		end
		else
		begin
			if (state == ST_WAIT_FALL && !i_dev_busy)
				done <= 1'b1;
			else if (wr_ack && i_address == CSR_STATUS && i_byteenable[0]
				&& i_writedata[STA_DONE])
				done <= 1'b0;
			if (state == ST_IDLE && start_req && calc_too_long)
				too_long_err <= 1'b1;
			else if (wr_ack && i_address == CSR_STATUS && i_byteenable[0]
				&& i_writedata[STA_TOO_LONG])
				too_long_err <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// setup arithmetic, snapshot in ST_WAIT_IDLE before the first engine write so later writes cannot disturb it

	line_setup_calc u_calc (
		.i_points(points),
		.i_texture_start(texture[19:16]),
		.i_single_dot(mode[1]),
		.i_xor_mode(mode[2]),
		.i_plane_width(plane_width),
		.i_plane_base(plane_base),
		.o_regs(calc_regs),
		.o_too_long(calc_too_long)
	);

	// snapshot while waiting for the engine: mode bits written with start are in place
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
			regs <= '0;
		else if (state == ST_WAIT_IDLE)
			regs <= calc_regs;
	end

	// write list; the size word is the final step
	always_comb
	begin
		entry = '0;
		case (step)
			4'h0: entry = '{DEV_FIRST_SOURCE_DATA, {16'h0000, LINE_BIT_PRESET}};
			4'h1: entry = '{DEV_TEXTURE_DATA, {16'h0000, texture[15:0]}};
			4'h2: entry = '{DEV_FIRST_WORD_MASK, {16'h0000, WORD_MASK_ALL}};
			4'h3: entry = '{DEV_LAST_WORD_MASK, {16'h0000, WORD_MASK_ALL}};
			4'h4: entry = '{DEV_FIRST_SOURCE_MODULO, {16'h0000, regs.first_modulo}};
			4'h5: entry = '{DEV_SECOND_SOURCE_MODULO, {16'h0000, regs.second_modulo}};
			4'h6: entry = '{DEV_ORIGINAL_SOURCE_MODULO, {16'h0000, plane_width}};
			4'h7: entry = '{DEV_DESTINATION_MODULO, {16'h0000, plane_width}};
			4'h8: entry = '{DEV_ERROR_TERM_POINTER, regs.error_term};
			4'h9: entry = '{DEV_ORIGINAL_SOURCE_POINTER, regs.first_pixel};
			4'ha: entry = '{DEV_DESTINATION_POINTER, regs.first_pixel};
			4'hb: entry = '{DEV_ENGINE_CONTROL_FIRST, {16'h0000, regs.control_first}};
			4'hc: entry = '{DEV_ENGINE_CONTROL_SECOND, {16'h0000, regs.control_second}};
			default: entry = '{DEV_OPERATION_SIZE_START, {16'h0000, regs.size}};
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	// start is ignored unless idle; an over-long line only raises the error flag
	always_comb
	begin
		next_state = state;
		next_step = step;
		send = 1'b0;
		case (state)
			ST_IDLE:
				if (start_req && !calc_too_long)
				begin
					next_state = ST_WAIT_IDLE;
					next_step = 4'h0;
				end
			ST_WAIT_IDLE:
				if (!i_dev_busy)
					next_state = ST_SEND;
			ST_SEND:
			begin
				send = 1'b1;
				next_state = ST_WAIT_ACK;
			end
			ST_WAIT_ACK:
				if (accepted)
				begin
					if (step == LAST_STEP)
						next_state = ST_WAIT_RISE;
					else
					begin
						next_step = step + 4'h1;
						next_state = ST_SEND;
					end
				end
			ST_WAIT_RISE:
				if (i_dev_busy)
					next_state = ST_WAIT_FALL;
			ST_WAIT_FALL:
				if (!i_dev_busy)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
		if (abort_req)
			next_state = ST_IDLE;
	end

	// state and step registers
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			state <= ST_IDLE;
			step <= 4'h0;
		end
		else
		begin
			state <= next_state;
			step <= next_step;
		end
	end

	// the port holds each write until the engine takes it
	dev_write_port u_port (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_send(send),
		.i_entry(entry),
		.o_accepted(accepted),
		.i_ready(i_dev_ready),
		.o_valid(o_dev_write),
		.o_entry(o_dev_entry)
	);

endmodule : line_draw_host

`default_nettype wire

// ---- hw/line_pkg.sv ----
/*
 * Constants and types for the host-side line-draw controller: its own
 * Avalon-MM register map, the device register indices it writes, field
 * positions of the device control words and the carriers between blocks.
 * Assumes a single 200 MHz clock domain shared by all users of the package.
 */
package line_pkg;

	////////////////////////////////////////////////////////////////////////
	// own register map, byte offsets on the Avalon-MM slave
	localparam logic [4:0] CSR_CONTROL = 5'h00;
	localparam logic [4:0] CSR_START_POINT = 5'h04;
	localparam logic [4:0] CSR_END_POINT = 5'h08;
	localparam logic [4:0] CSR_TEXTURE = 5'h0c;
	localparam logic [4:0] CSR_PLANE_WIDTH = 5'h10;
	localparam logic [4:0] CSR_PLANE_BASE = 5'h14;
	localparam logic [4:0] CSR_STATUS = 5'h18;

	// control and status bit positions
	localparam int CTL_START = 0;
	localparam int CTL_SINGLE_DOT = 1;
	localparam int CTL_XOR_MODE = 2;
	localparam int CTL_ABORT = 3;
	localparam int STA_BUSY = 0;
	localparam int STA_DONE = 1;
	localparam int STA_TOO_LONG = 2;

	////////////////////////////////////////////////////////////////////////
	// device register indices, written over the device port
	localparam logic [7:0] DEV_FIRST_SOURCE_DATA = 8'h00;
	localparam logic [7:0] DEV_TEXTURE_DATA = 8'h01;
	localparam logic [7:0] DEV_FIRST_WORD_MASK = 8'h02;
	localparam logic [7:0] DEV_LAST_WORD_MASK = 8'h03;
	localparam logic [7:0] DEV_FIRST_SOURCE_MODULO = 8'h04;
	localparam logic [7:0] DEV_SECOND_SOURCE_MODULO = 8'h05;
	localparam logic [7:0] DEV_ORIGINAL_SOURCE_MODULO = 8'h06;
	localparam logic [7:0] DEV_DESTINATION_MODULO = 8'h07;
	localparam logic [7:0] DEV_ERROR_TERM_POINTER = 8'h08;
	localparam logic [7:0] DEV_ORIGINAL_SOURCE_POINTER = 8'h09;
	localparam logic [7:0] DEV_DESTINATION_POINTER = 8'h0a;
	localparam logic [7:0] DEV_ENGINE_CONTROL_FIRST = 8'h0b;
	localparam logic [7:0] DEV_ENGINE_CONTROL_SECOND = 8'h0c;
	localparam logic [7:0] DEV_OPERATION_SIZE_START = 8'h0d;
	localparam logic [3:0] LAST_STEP = 4'hd;

	////////////////////////////////////////////////////////////////////////
	// device field positions and fixed line-mode values
	localparam int CON_SHIFT_LSB = 12;
	localparam int CON0_FIRST_SOURCE_ENABLE = 11;
	localparam int CON0_SECOND_SOURCE_ENABLE = 10;
	localparam int CON0_ORIGINAL_SOURCE_ENABLE = 9;
	localparam int CON0_DESTINATION_ENABLE = 8;
	localparam int CON1_ERROR_NEGATIVE_FLAG = 6;
	localparam int CON1_OVERFLOW_FLAG = 5;
	localparam int CON1_OCTANT_LSB = 2;
	localparam int CON1_SINGLE_DOT_PER_ROW = 1;
	localparam int CON1_LINE_SELECT = 0;
	localparam int SIZE_HEIGHT_LSB = 6;
	localparam logic [7:0] LOGIC_PLAIN_LINE = 8'hca;
	localparam logic [7:0] LOGIC_XOR_LINE = 8'h4a;
	localparam logic [15:0] LINE_BIT_PRESET = 16'h8000;
	localparam logic [15:0] WORD_MASK_ALL = 16'hffff;
	localparam logic [5:0] LINE_WIDTH_WORDS = 6'h02;
	localparam logic [15:0] SHIFT_MODULUS = 16'h000f;
	localparam logic [16:0] LINE_MAX_PIXELS = 17'h00400;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [15:0] x1;
		logic [15:0] y1;
		logic [15:0] x2;
		logic [15:0] y2;
	} line_points_t;

	typedef struct packed {
		logic [15:0] control_first;
		logic [15:0] control_second;
		logic [15:0] size;
		logic [15:0] first_modulo;
		logic [15:0] second_modulo;
		logic [31:0] error_term;
		logic [31:0] first_pixel;
	} line_regs_t;

	typedef struct packed {
		logic [7:0] index;
		logic [31:0] data;
	} dev_write_t;

	// octant number to the three code bits of the second control word
	function automatic logic [2:0] octant_code(input logic [2:0] octant);
		case (octant)
			3'h0: octant_code = 3'h6;
			3'h1: octant_code = 3'h1;
			3'h2: octant_code = 3'h3;
			3'h3: octant_code = 3'h7;
			3'h4: octant_code = 3'h5;
			3'h5: octant_code = 3'h2;
			3'h6: octant_code = 3'h0;
			default: octant_code = 3'h4;
		endcase
	endfunction : octant_code

endpackage : line_pkg

// ---- hw/line_setup_calc.sv ----
/*
 * Combinational setup arithmetic: turns two endpoints and the plane
 * geometry into the line-mode words for the device.
 * Assumes inputs stay stable while the caller samples the outputs.
 */
`timescale 1ns/1ps
`default_nettype none

module line_setup_calc (
	// line description
	input wire line_pkg::line_points_t i_points,
	input wire logic [3:0] i_texture_start,
	input wire logic i_single_dot,
	input wire logic i_xor_mode,
	// plane geometry
	input wire logic [15:0] i_plane_width,
	input wire logic [31:0] i_plane_base,
	// results
	output line_pkg::line_regs_t o_regs,
	output logic o_too_long
);
	import line_pkg::*;

	logic [16:0] diff_x, diff_y, abs_x, abs_y;
	logic [15:0] dx, dy, shift_rem;
	logic [18:0] err;
	logic [17:0] step_down;
	logic [16:0] pixels;
	logic [2:0] octant;
	logic x_major;

	// normalise to octant 0: major delta and minor delta
	always_comb
	begin
		diff_x = {1'b0, i_points.x2} - {1'b0, i_points.x1};
		diff_y = {1'b0, i_points.y2} - {1'b0, i_points.y1};
		abs_x = diff_x[16] ? 17'(-diff_x) : diff_x;
		abs_y = diff_y[16] ? 17'(-diff_y) : diff_y;
		x_major = abs_x >= abs_y;
		dx = x_major ? abs_x[15:0] : abs_y[15:0];
		dy = x_major ? abs_y[15:0] : abs_x[15:0];
		case ({diff_y[16], diff_x[16], x_major})
			3'b001: octant = 3'h0;
			3'b000: octant = 3'h1;
			3'b010: octant = 3'h2;
			3'b011: octant = 3'h3;
			3'b111: octant = 3'h4;
			3'b110: octant = 3'h5;
			3'b100: octant = 3'h6;
			default: octant = 3'h7;
		endcase
		err = {1'b0, dy, 2'b00} - {2'b00, dx, 1'b0};
		step_down = {dy, 2'b00} - {dx, 2'b00};
		pixels = {1'b0, dx} + 17'h00001;
		shift_rem = i_points.x1 % SHIFT_MODULUS;
	end

	// pack the device words
	always_comb
	begin
		o_too_long = pixels > LINE_MAX_PIXELS;
		o_regs.control_first = {shift_rem[3:0], 4'h0,
			i_xor_mode ? LOGIC_XOR_LINE : LOGIC_PLAIN_LINE};
		o_regs.control_first[CON0_FIRST_SOURCE_ENABLE] = 1'b1;
		o_regs.control_first[CON0_ORIGINAL_SOURCE_ENABLE] = 1'b1;
		o_regs.control_first[CON0_DESTINATION_ENABLE] = 1'b1;
		o_regs.control_first[CON0_SECOND_SOURCE_ENABLE] = 1'b0;
		o_regs.control_second = {i_texture_start, 12'h000};
		o_regs.control_second[CON1_OCTANT_LSB +: 3] = octant_code(octant);
		o_regs.control_second[CON1_ERROR_NEGATIVE_FLAG] = err[18];
		o_regs.control_second[CON1_OVERFLOW_FLAG] = 1'b0;
		o_regs.control_second[CON1_SINGLE_DOT_PER_ROW] = i_single_dot;
		o_regs.control_second[CON1_LINE_SELECT] = 1'b1;
		o_regs.size = {pixels[9:0], LINE_WIDTH_WORDS};
		o_regs.first_modulo = step_down[15:0];
		o_regs.second_modulo = {dy[13:0], 2'b00};
		o_regs.error_term = {{13{err[18]}}, err};
		o_regs.first_pixel = i_plane_base + 32'(i_points.y1) * 32'(i_plane_width)
			+ {19'h00000, i_points.x1[15:4], 1'b0};
	end

endmodule : line_setup_calc

`default_nettype wire

// ---- hw/dev_write_port.sv ----
/*
 * One-deep register write port toward the device: holds index and data
 * until the device signals ready, then reports acceptance for one cycle.
 * Assumes the device samples valid, index and data on a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module dev_write_port (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// request from the sequencer
	input wire logic i_send,
	input wire line_pkg::dev_write_t i_entry,
	output logic o_accepted,
	// device side
	input wire logic i_ready,
	output logic o_valid,
	output line_pkg::dev_write_t o_entry
);
	import line_pkg::*;

	// a send while a write is still held is dropped; the sequencer never does it
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			o_valid <= 1'b0;
			o_entry <= '0;
			o_accepted <= 1'b0;
		end
		else
		begin
			o_accepted <= o_valid && i_ready;
			if (o_valid && i_ready)
				o_valid <= 1'b0;
			else if (!o_valid && i_send)
			begin
				o_valid <= 1'b1;
				o_entry <= i_entry;
			end
		end
	end

endmodule : dev_write_port

`default_nettype wire

// ---- test/line_draw_host_asserts.sv ----
/*
 * Checker for line_draw_host: bus answer, engine write order, fixed line fields.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module line_draw_host_asserts (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// avalon-mm slave
	input wire logic [4:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [3:0] i_byteenable,
	input wire logic [31:0] i_writedata,
	input wire logic [31:0] o_readdata,
	input wire logic o_waitrequest,
	// engine register port
	input wire logic o_dev_write,
	input wire line_pkg::dev_write_t o_dev_entry,
	input wire logic i_dev_ready,
	input wire logic i_dev_busy
);
	import line_pkg::*;

	logic take;
	logic [3:0] last_index;
	logic [15:0] first_mod;
	logic [15:0] second_mod;
	logic err_neg;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);

	assign take = o_dev_write && i_dev_ready;

	// keep what the engine already took, later words are judged against it
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
			last_index <= 4'hd;
		else if (take)
			last_index <= o_dev_entry.index[3:0];
	end

	// modulos and error sign feed the size and sign checks
	always_ff @(posedge i_clock)
	begin
		if (take && o_dev_entry.index == DEV_FIRST_SOURCE_MODULO)
			first_mod <= o_dev_entry.data[15:0];
		if (take && o_dev_entry.index == DEV_SECOND_SOURCE_MODULO)
			second_mod <= o_dev_entry.data[15:0];
		if (take && o_dev_entry.index == DEV_ERROR_TERM_POINTER)
			err_neg <= o_dev_entry.data[31];
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_taken;
		(i_read || i_write) && o_waitrequest;
	endsequence
	sequence s_answer;
		!o_waitrequest ##1 o_waitrequest;
	endsequence
	sequence s_stall;
		o_dev_write && !i_dev_ready;
	endsequence

	property p_answer;
		s_taken |=> s_answer;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer not one cycle");

	property p_hold;
		s_stall |=> o_dev_write && $stable(o_dev_entry);
	endproperty
	a_hold: assert property (p_hold) else $error("engine write dropped early");

	property p_order;
		take && o_dev_entry.index != 8'h00 |-> o_dev_entry.index[3:0] == last_index + 4'h1;
	endproperty
	a_order: assert property (p_order) else $error("engine write out of order");

	property p_line_bit;
		take && o_dev_entry.index == DEV_FIRST_SOURCE_DATA |-> o_dev_entry.data[15:0] == 16'h8000;
	endproperty
	a_line_bit: assert property (p_line_bit) else $error("line bit word wrong");

	property p_masks;
		take && o_dev_entry.index inside {8'h02, 8'h03} |-> o_dev_entry.data[15:0] == 16'hffff;
	endproperty
	a_masks: assert property (p_masks) else $error("word mask wrong");

	property p_channels;
		take && o_dev_entry.index == DEV_ENGINE_CONTROL_FIRST
			|-> o_dev_entry.data[11:8] == 4'hb && o_dev_entry.data[7:0] inside {8'hca, 8'h4a};
	endproperty
	a_channels: assert property (p_channels) else $error("channels or logic wrong");

	property p_line_mode;
		take && o_dev_entry.index == DEV_ENGINE_CONTROL_SECOND
			|-> o_dev_entry.data[0] && !o_dev_entry.data[5] && o_dev_entry.data[6] == err_neg;
	endproperty
	a_line_mode: assert property (p_line_mode) else $error("second control wrong");

	property p_size;
		take && o_dev_entry.index == DEV_OPERATION_SIZE_START |-> o_dev_entry.data[5:0] == 6'h02
			&& o_dev_entry.data[15:6] == 10'(((second_mod - first_mod) >> 2) + 16'h1);
	endproperty
	a_size: assert property (p_size) else $error("size word wrong");

	property p_quiet_busy;
		o_dev_write |-> !i_dev_busy;
	endproperty
	a_quiet_busy: assert property (p_quiet_busy) else $error("write while engine busy");

endmodule : line_draw_host_asserts

bind line_draw_host line_draw_host_asserts line_draw_host_asserts_i (
	.i_clock(i_clock),
	.i_reset_n(i_reset_n),
	.i_address(i_address),
	.i_read(i_read),
	.i_write(i_write),
	.i_byteenable(i_byteenable),
	.i_writedata(i_writedata),
	.o_readdata(o_readdata),
	.o_waitrequest(o_waitrequest),
	.o_dev_write(o_dev_write),
	.o_dev_entry(o_dev_entry),
	.i_dev_ready(i_dev_ready),
	.i_dev_busy(i_dev_busy)
);

`default_nettype wire

// ---- test/engine_model.sv ----
/*
 * Behavioural line engine: takes register writes, draws for eight clocks a pixel.
 * Assumes one clock; ready is prompt or one cycle in three when slow.
 */
`timescale 1ns/1ps
`default_nettype none

module engine_model (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_slow,
	// register port
	input wire logic i_dev_write,
	input wire line_pkg::dev_write_t i_dev_entry,
	output logic o_dev_ready,
	output logic o_dev_busy,
	// observation
	output var logic [31:0] o_regs [14],
	output var int o_writes,
	output logic o_order_bad
);
	import line_pkg::*;

	logic [1:0] phase;
	logic [13:0] left;

	// size word starts the line with the held values, busy for eight clocks a pixel
	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			phase <= 2'h0;
			o_dev_ready <= 1'b0;
			left <= 14'h0;
			o_writes <= 0;
			o_order_bad <= 1'b0;
		end
		else
		begin
			phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
			o_dev_ready <= !i_slow || phase == 2'h1;
			if (left != 14'h0)
				left <= left - 14'h1;
			if (i_dev_write && o_dev_ready && i_dev_entry.index < 8'h0e)
			begin
				o_regs[i_dev_entry.index[3:0]] <= i_dev_entry.data;
				o_writes <= o_writes + 1;
				if (o_dev_busy || i_dev_entry.index[3:0] != 4'(o_writes % 14))
					o_order_bad <= 1'b1;
				if (i_dev_entry.index == DEV_OPERATION_SIZE_START)
					left <= {~|i_dev_entry.data[15:6], i_dev_entry.data[15:6], 3'h0};
			end
		end
	end

	// busy follows the pixel count and lags the size write, as sources are fetched first
	always_ff @(posedge i_clock)
		o_dev_busy <= i_reset_n && left != 14'h0;

endmodule : engine_model

`default_nettype wire

// ---- test/line_draw_host_tb.sv ----
/*
 * Testbench for line_draw_host: draws lines in all octants and checks every
 * engine word. Assumes engine_model on the engine port and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

module line_draw_host_tb;
	import line_pkg::*;

	logic i_clock, i_reset_n, i_read, i_write, o_waitrequest, o_dev_write, dev_ready;
	logic dev_busy, slow, order_bad;
	logic [4:0] i_address;
	logic [31:0] i_writedata, o_readdata;
	dev_write_t o_dev_entry;
	logic [31:0] dev_regs [14];
	int dev_writes, checked, miscompares, i;
	logic [2:0] dirs [8] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h7, 3'h6, 3'h4, 3'h5};
	logic [2:0] codes [8] = '{3'h6, 3'h1, 3'h3, 3'h7, 3'h5, 3'h2, 3'h0, 3'h4};

	line_draw_host line_draw_host_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_address(i_address), .i_read(i_read), .i_write(i_write), .i_byteenable(4'hf),
		.i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
		.o_dev_write(o_dev_write), .o_dev_entry(o_dev_entry), .i_dev_ready(dev_ready),
		.i_dev_busy(dev_busy));
	engine_model engine_model_i (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_slow(slow),
		.i_dev_write(o_dev_write), .i_dev_entry(o_dev_entry), .o_dev_ready(dev_ready),
		.o_dev_busy(dev_busy), .o_regs(dev_regs), .o_writes(dev_writes),
		.o_order_bad(order_bad));

	// free-running 200 MHz clock
	always #2.5 i_clock = ~i_clock;

	////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want)
		begin
			miscompares++;
			$display("BAD t=%0t seen %h want %h", $time, seen, want);
		end
	endtask : check

	// one bus cycle; read data stands at the edge where waitrequest is seen low
	task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] v);
		int n;
		@(posedge i_clock);
		i_address <= a;
		i_writedata <= d;
		i_write <= wr;
		i_read <= !wr;
		for (n = 0; n < 50 && o_waitrequest !== 1'b0; n++)
			@(posedge i_clock);
		i_write <= 1'b0;
		i_read <= 1'b0;
		v = o_readdata;
		if (n == 50)
		begin
			miscompares++;
			final_report;
		end
	endtask : av

	task automatic t_reset;
		logic [31:0] v;
		check({o_waitrequest, o_dev_write}, 32'h2);
		av(1'b1, 5'h1c, 32'hffff_ffff, v);
		av(1'b0, 5'h1c, 32'h0, v);
		check(v, 32'h0);
		av(1'b0, CSR_STATUS, 32'h0, v);
		check(v, 32'h0);
	endtask : t_reset

	// one line in octant oct; a length over 1024 must be refused
	task automatic t_line(input logic [2:0] oct, input logic [15:0] maj, input logic [15:0] mnr,
		input logic sdot, input logic xr, input logic again);
		logic [2:0] d;
		logic [15:0] x1, y1, ax, ay;
		logic [31:0] e, st, fp, got;
		logic [31:0] want [14];
		int n0, k;
		d = dirs[oct];
		x1 = 16'd40 + {13'h0, oct};
		y1 = 16'd20;
		ax = d[0] ? maj : mnr;
		ay = d[0] ? mnr : maj;
		e = 4 * mnr - 2 * maj;
		fp = 32'h0001_0000 + 32'(y1) * 40 + 2 * (x1 >> 4);
		n0 = dev_writes;
		av(1'b1, CSR_START_POINT, {y1, x1}, st);
		av(1'b1, CSR_END_POINT, {d[2] ? y1 - ay : y1 + ay, d[1] ? x1 - ax : x1 + ax}, st);
		av(1'b1, CSR_TEXTURE, {12'h0, {1'b0, oct} + 4'h3, 16'hf0f0 ^ {13'h0, oct}}, st);
		av(1'b1, CSR_PLANE_WIDTH, 32'd40, st);
		av(1'b1, CSR_PLANE_BASE, 32'h0001_0000, st);
		av(1'b1, CSR_CONTROL, {29'h0, xr, sdot, 1'b1}, st);
		if (again)
			av(1'b1, CSR_CONTROL, {29'h0, xr, sdot, 1'b1}, st);
		st = 32'h0;
		for (k = 0; k < 6000 && st[2:1] == 2'h0; k++)
			av(1'b0, CSR_STATUS, 32'h0, st);
		if (k == 6000)
		begin
			miscompares++;
			final_report;
		end
		check(st & 32'h6, maj > 16'd1023 ? 32'h4 : 32'h2);
		check(32'(dev_writes - n0), maj > 16'd1023 ? 32'h0 : 32'd14);
		check({31'h0, order_bad}, 32'h0);
		av(1'b1, CSR_STATUS, 32'h6, st);
		av(1'b0, CSR_STATUS, 32'h0, st);
		check(st & 32'h6, 32'h0);
		if (maj < 16'd1024)
		begin
			want = '{32'h8000, {16'h0, 16'hf0f0 ^ {13'h0, oct}}, 32'hffff, 32'hffff,
				{16'h0, 16'(4 * (mnr - maj))}, {16'h0, 16'(4 * mnr)}, 32'd40, 32'd40, e, fp, fp,
				{16'h0, 4'(x1 % 16'd15), 4'hb, xr ? 8'h4a : 8'hca},
				{16'h0, {1'b0, oct} + 4'h3, 5'h0, e[31], 1'b0, codes[oct], sdot, 1'b1},
				{16'h0, 10'(maj + 16'd1), 6'h2}};
			for (k = 0; k < 14; k++)
			begin
				got = (k > 7 && k < 11) ? dev_regs[k] : {16'h0, dev_regs[k][15:0]};
				check(got, want[k]);
			end
		end
	endtask : t_line

	////////////////////////////////////////////////////////////////////////
	// main sequence: reset, eight octants, longest line with repeat start, refused line
	initial
	begin
		i_clock = 1'b0;
		i_reset_n = 1'b0;
		{i_read, i_write, slow} = 3'h0;
		i_address = 5'h0;
		i_writedata = 32'h0;
		checked = 0;
		miscompares = 0;
		repeat (20) @(posedge i_clock);
		i_reset_n <= 1'b1;
		t_reset;
		for (i = 0; i < 8; i++)
			t_line(3'(i), 16'd9, i[0] ? 16'd6 : 16'd3, i[1], i[2], 1'b0);
		slow <= 1'b1;
		t_line(3'h0, 16'd1023, 16'd500, 1'b0, 1'b0, 1'b1);
		t_line(3'h1, 16'd1024, 16'd3, 1'b1, 1'b0, 1'b0);
		final_report;
	end

endmodule : line_draw_host_tb

`default_nettype wire
